// file: rtl/acq_ctl_regs.vh
/*
  Constants for the acquisition control register block: serial word layout,
  register address, field positions and reset value.
  Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef ACQ_CTL_REGS_VH
`define ACQ_CTL_REGS_VH

// Serial command word layout
`define WORD_BITS          32
`define WORD_RW_BIT        31
`define WORD_ADDR_HI       30
`define WORD_ADDR_LO       24
`define WORD_DATA_HI       23
`define WORD_DATA_LO       0

// Register addresses
`define ADDR_NOP           7'h00
`define ADDR_ACQ_CTL       7'h01

// Field positions of acquisition_control
`define BIT_LEFT_ARM_ON    23
`define BIT_LEFT_LEG_ON    22
`define BIT_RIGHT_ARM_ON   21
`define BIT_TOPOLOGY       10
`define BIT_GAIN_HI        9
`define BIT_GAIN_LO        8
`define BIT_REF_BUF_ON     7
`define BIT_CLK_SOURCE     6
`define BIT_GANG_MASTER    5
`define BIT_GANG_ON        4
`define BIT_RATE_SEL       3
`define BIT_CONV_RUN       2
`define BIT_POWER_ON       1
`define BIT_SOFT_RESET     0

// Writable bits; reserved bits 20:11 read as zero
`define ACQ_CTL_MASK       24'hE007FF
`define ACQ_CTL_RESET      24'h000000

`endif

// file: rtl/acq_ctl_block.v
/*
  Acquisition control register of a three-channel biopotential front end,
  with its serial command port (mode 0 style: sample on rising link clock,
  shift out on falling link clock, MSB first, frame by active-low select).
  Assumes the link clock, select and data input arrive asynchronously and
  are far slower than core_clk (link clock 12.5 MHz vs 100 MHz core).
*/
`timescale 1ns/10ps

`include "acq_ctl_regs.vh"

// Function
// - Command word is 32 bits: read/write flag, 7-bit address, 24 data bits MSB first.
// - Bits 23..21 enable the three channels; zero powers a channel down.
// - Bit 10 selects single-ended (0) or differential (1) inputs.
// - Bits 9:8 set preamp gain code; top code needs user gain calibration.
// - Bit 6 picks crystal (0) or shared clock pin (1) as clock source.
// - Crystal is switched off when the device is a gang-mode slave.
// - Bit 5 picks gang master, driving the sync pin; ignored outside gang mode.
// - Bit 4 enables gang mode, activating clock pin and sync pin.
// - Bit 3 selects 1 MSPS low power or 2 MSPS low noise.
// - Bit 2 runs conversions and filters; clear leaves them idle.
// - Clearing bit 1 powers down analog and crystal; registers keep contents.
// - Writing one to bit 0 starts soft reset of all registers; bit self-clears.
// - Soft reset completes only when a following no-operation command arrives.
module acq_ctl_block
(
  input  wire        core_clk,
  input  wire        reset,
  input  wire        linkClk,
  input  wire        linkSelN,
  input  wire        linkDataIn,
  output reg         linkDataOut,
  output reg         linkDataOutEn,
  output reg         left_arm_channel_on,
  output reg         left_leg_channel_on,
  output reg         right_arm_channel_on,
  output reg         input_topology_select,
  output reg  [1:0]  gainCode,
  output reg         reference_buffer_on,
  output reg         clock_source_select,
  output reg         crystalEnable,
  output reg         gangOn,
  output reg         gangMaster,
  output reg         gangSyncOutEn,
  output reg         sample_rate_select,
  output reg         conversion_run,
  output reg         power_on,
  output reg         softResetPending
);

  // Synchroniser stages for the link pins
  reg  [1:0]  clkSync_reg;
  reg  [1:0]  selSync_reg;
  reg  [1:0]  dinSync_reg;
  reg         clkPrev_reg;

  // Serial engine state
  reg  [31:0] shiftIn_reg;
  reg  [5:0]  bitCount_reg;
  reg  [23:0] shiftOut_reg;
  reg         isRead_reg;
  reg  [23:0] ctl_reg;
  reg         resetArmed_reg;

  wire        clkRise;
  wire        clkFall;
  wire        selActive;
  wire [31:0] wordNow;
  wire [6:0]  wordAddr;
  wire        wordDone;

  // Read value for the address of a word whose first byte has arrived (for read setup)
  function [23:0] readValue;
    input [6:0]  addr;
    input [23:0] ctl;
    begin
      if (addr == `ADDR_ACQ_CTL)
        readValue = ctl & `ACQ_CTL_MASK;
      else
        readValue = 24'h000000;
    end
  endfunction

  // Edge detect on the second synchroniser stage only
  assign clkRise   = clkSync_reg[1] & ~clkPrev_reg;
  assign clkFall   = ~clkSync_reg[1] & clkPrev_reg;
  assign selActive = ~selSync_reg[1];
  assign wordNow   = {shiftIn_reg[30:0], dinSync_reg[1]};
  assign wordAddr  = wordNow[`WORD_ADDR_HI:`WORD_ADDR_LO];
  assign wordDone  = selActive & clkRise & (bitCount_reg == 6'h1F);

  // Two-flop synchronisers
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      clkSync_reg <= 2'h0;
      selSync_reg <= 2'h3;
      dinSync_reg <= 2'h0;
      clkPrev_reg <= 1'b0;
    end
    else
    begin
      clkSync_reg <= {clkSync_reg[0], linkClk};
      selSync_reg <= {selSync_reg[0], linkSelN};
      dinSync_reg <= {dinSync_reg[0], linkDataIn};
      clkPrev_reg <= clkSync_reg[1];
    end
  end

  // Shift in command bits MSB first, count to a full word
  always @(posedge core_clk)
  begin
    if (reset || !selActive)
    begin
      shiftIn_reg  <= 32'h00000000;
      bitCount_reg <= 6'h00;
    end
    else if (clkRise)
    begin
      shiftIn_reg  <= wordNow;
      bitCount_reg <= (bitCount_reg == 6'h1F) ? 6'h00 : bitCount_reg + 6'h01;
    end
  end

  // Read data: load after the 8-bit header, shift on falling edges
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      shiftOut_reg  <= 24'h000000;
      isRead_reg    <= 1'b0;
      linkDataOut   <= 1'b0;
      linkDataOutEn <= 1'b0;
    end
    else
    begin
      linkDataOutEn <= selActive & isRead_reg;
      if (!selActive)
        isRead_reg <= 1'b0;
      else if (clkRise && bitCount_reg == 6'h07)
      begin
        isRead_reg   <= ~wordNow[7];
        shiftOut_reg <= readValue(wordNow[6:0], ctl_reg);
      end
      else if (clkFall && isRead_reg && bitCount_reg >= 6'h08)
      begin
        linkDataOut  <= shiftOut_reg[23];
        shiftOut_reg <= {shiftOut_reg[22:0], 1'b0};
      end
      if (clkRise && bitCount_reg == 6'h1F)
        isRead_reg <= 1'b0;
    end
  end

  // Control register, soft reset handshake
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      ctl_reg        <= `ACQ_CTL_RESET;
      resetArmed_reg <= 1'b0;
    end
    else if (wordDone)
    begin
      if (resetArmed_reg && wordAddr == `ADDR_NOP)
      begin
        ctl_reg        <= `ACQ_CTL_RESET;
        resetArmed_reg <= 1'b0;
      end
      else if (wordNow[`WORD_RW_BIT] && wordAddr == `ADDR_ACQ_CTL)
      begin
        ctl_reg        <= wordNow[23:0] & `ACQ_CTL_MASK & ~24'h000001;
        resetArmed_reg <= resetArmed_reg | wordNow[`BIT_SOFT_RESET];
      end
    end
  end

  // Decode fields to registered control outputs
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      left_arm_channel_on   <= 1'b0;
      left_leg_channel_on   <= 1'b0;
      right_arm_channel_on  <= 1'b0;
      input_topology_select <= 1'b0;
      gainCode              <= 2'h0;
      reference_buffer_on   <= 1'b0;
      clock_source_select   <= 1'b0;
      crystalEnable         <= 1'b0;
      gangOn                <= 1'b0;
      gangMaster            <= 1'b0;
      gangSyncOutEn         <= 1'b0;
      sample_rate_select    <= 1'b0;
      conversion_run        <= 1'b0;
      power_on              <= 1'b0;
      softResetPending      <= 1'b0;
    end
    else
    begin
      left_arm_channel_on   <= ctl_reg[`BIT_LEFT_ARM_ON];
      left_leg_channel_on   <= ctl_reg[`BIT_LEFT_LEG_ON];
      right_arm_channel_on  <= ctl_reg[`BIT_RIGHT_ARM_ON];
      input_topology_select <= ctl_reg[`BIT_TOPOLOGY];
      gainCode              <= ctl_reg[`BIT_GAIN_HI:`BIT_GAIN_LO];
      reference_buffer_on   <= ctl_reg[`BIT_REF_BUF_ON];
      clock_source_select   <= ctl_reg[`BIT_CLK_SOURCE];
      crystalEnable         <= ctl_reg[`BIT_POWER_ON] & ~ctl_reg[`BIT_CLK_SOURCE]
                               & ~(ctl_reg[`BIT_GANG_ON] & ~ctl_reg[`BIT_GANG_MASTER]);
      gangOn                <= ctl_reg[`BIT_GANG_ON];
      gangMaster            <= ctl_reg[`BIT_GANG_ON] & ctl_reg[`BIT_GANG_MASTER];
      gangSyncOutEn         <= ctl_reg[`BIT_GANG_ON] & ctl_reg[`BIT_GANG_MASTER];
      sample_rate_select    <= ctl_reg[`BIT_RATE_SEL];
      conversion_run        <= ctl_reg[`BIT_CONV_RUN] & ctl_reg[`BIT_POWER_ON];
      power_on              <= ctl_reg[`BIT_POWER_ON];
      softResetPending      <= resetArmed_reg;
    end
  end

endmodule // acq_ctl_block

// file: testbench/acq_ctl_block_asserts.sv
/* Port checker for acq_ctl_block.
   Assumes one core_clk domain and synchronous active-high reset. */
`timescale 1ns/10ps
module acq_ctl_block_asserts
(
  input wire       core_clk,
  input wire       reset,
  input wire       linkSelN,
  input wire       linkDataOutEn,
  input wire       left_arm_channel_on,
  input wire [1:0] gainCode,
  input wire       clock_source_select,
  input wire       crystalEnable,
  input wire       gangOn,
  input wire       gangMaster,
  input wire       gangSyncOutEn,
  input wire       conversion_run,
  input wire       power_on,
  input wire       softResetPending
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Link idle long enough for any word to land
  sequence selIdle;
    linkSelN [*8];
  endsequence
  // Left arm, gain, power, gang and pending fields back at zero
  sequence fieldsClear;
    !left_arm_channel_on && gainCode == 2'h0 && !power_on && !gangOn && !softResetPending;
  endsequence
  a_out_idle: assert property (linkSelN [*6] |-> !linkDataOutEn)
    else $error("read driver on outside frame");
  a_idle_stable: assert property (selIdle |=> $stable({left_arm_channel_on, gainCode, power_on, crystalEnable}))
    else $error("fields changed with link idle");
  a_master_pin: assert property ((gangMaster || gangSyncOutEn) |-> gangOn && gangMaster && gangSyncOutEn)
    else $error("master role outside gang mode");
  a_slave_crystal_oscillator: assert property (gangOn && !gangMaster |-> !crystalEnable)
    else $error("crystal on as slave");
  a_ext_clk: assert property (clock_source_select |-> !crystalEnable)
    else $error("crystal on with shared clock");
  a_power_gate: assert property (!power_on |-> !crystalEnable && !conversion_run)
    else $error("activity while powered down");
  a_reset_done: assert property ($fell(softResetPending) |-> ##[0:2] fieldsClear)
    else $error("soft reset left fields set");
  a_crystal_oscillator_run: assert property (power_on && !clock_source_select && !gangOn |-> crystalEnable)
    else $error("crystal off when needed");
endmodule // acq_ctl_block_asserts

// file: testbench/spi_host_model.sv
/* Host serial master: mode 0, 80 ns link clock, MSB first.
   Assumes calls start just after a core_clk rising edge. */
`timescale 1ns/10ps
module spi_host_model
(
  output logic linkClk,
  output logic linkSelN,
  output logic linkDataIn,
  input  wire  linkDataOut
);
  // Idle link: clock low, deselected
  initial
  begin
    linkClk = 1'b0;
    linkSelN = 1'b1;
    linkDataIn = 1'b0;
  end
  // Shift n bits of w, capture reply before each fall
  task xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    int i;
    begin
      r = 32'h0;
      linkSelN = 1'b0;
      for (i = 31; i > 31 - n; i--)
      begin
        linkDataIn = w[i];
        #40 linkClk = 1'b1;
        #35 r[i] = linkDataOut;
        #5 linkClk = 1'b0;
      end
      #40 linkSelN = 1'b1;
      linkDataIn = ~linkDataIn; // Data line flipped after deselect
      #400;
    end
  endtask
endmodule // spi_host_model

// file: testbench/acq_ctl_block_tb.sv
/* Self-checking bench for acq_ctl_block.
   Uses spi_host_model on the link; binds the port checker. */
`timescale 1ns/10ps
module acq_ctl_block_tb;
  logic        core_clk;
  logic        reset;
  wire         linkClk, linkSelN, linkDataIn, linkDataOut, linkDataOutEn;
  wire         left_arm_channel_on, left_leg_channel_on, right_arm_channel_on, input_topology_select;
  wire  [1:0]  gainCode;
  wire         reference_buffer_on, clock_source_select, crystalEnable, gangOn, gangMaster;
  wire         gangSyncOutEn, sample_rate_select, conversion_run, power_on, softResetPending;
  int          fails, checked;
  logic [31:0] r;
  wire  [15:0] obs = {left_arm_channel_on, left_leg_channel_on, right_arm_channel_on, input_topology_select,
    gainCode, reference_buffer_on, clock_source_select, crystalEnable, gangOn, gangMaster, gangSyncOutEn,
    sample_rate_select, conversion_run, power_on, softResetPending};
  acq_ctl_block DUT (.core_clk, .reset, .linkClk, .linkSelN, .linkDataIn, .linkDataOut, .linkDataOutEn,
    .left_arm_channel_on, .left_leg_channel_on, .right_arm_channel_on, .input_topology_select, .gainCode,
    .reference_buffer_on, .clock_source_select, .crystalEnable, .gangOn, .gangMaster, .gangSyncOutEn,
    .sample_rate_select, .conversion_run, .power_on, .softResetPending);
  spi_host_model host (.linkClk, .linkSelN, .linkDataIn, .linkDataOut);
  // Expected outputs for a control word
  function automatic logic [15:0] expv(input logic [23:0] d);
    expv = {d[23:21], d[10:6], d[1] & ~d[6] & ~(d[4] & ~d[5]), d[4], {2{d[4] & d[5]}}, d[3], d[2] & d[1], d[1], d[0]};
  endfunction
  task chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    begin
      checked++;
      if (s !== e)
      begin
        fails++;
        $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // Write a word, compare outputs and read-back
  task t_write(input logic [23:0] d);
    begin
      fork
        host.xfer({8'h81, d}, 32, r);
        #1500 chk("write en", 24'h0, {23'h0, linkDataOutEn});
      join
      chk("fields", {8'h0, expv(d)}, {8'h0, obs});
      fork
        host.xfer({8'h01, 24'h0}, 32, r);
        #1500 chk("read en", 24'h1, {23'h0, linkDataOutEn});
      join
      chk("readback", d & 24'hE007FE, r[23:0]);
    end
  endtask
  // Every field but soft reset (bit 0), each gain code and gang role
  task t_fields;
    logic [23:0] tbl [7] = '{24'hE00002, 24'h00070E, 24'h000132, 24'h000216, 24'h000044, 24'h000022, 24'hFFFFFE};
    begin
      foreach (tbl[k]) t_write(tbl[k]);
    end
  endtask
  // Other address, partial word
  task t_refused;
    begin
      host.xfer({8'h85, 24'h000002}, 32, r);
      host.xfer({8'h05, 24'h0}, 32, r);
      chk("other rd", 24'h0, r[23:0]);
      host.xfer({8'h81, 24'h000002}, 16, r);
      chk("kept", {8'h0, expv(24'hFFFFFE)}, {8'h0, obs});
    end
  endtask
  // Soft reset waits for a NOP
  task t_soft;
    begin
      t_write(24'hA00083);
      host.xfer({8'h85, 24'h0}, 32, r);
      chk("pending", {8'h0, expv(24'hA00083)}, {8'h0, obs});
      host.xfer(32'h80000000, 32, r);
      chk("cleared", 24'h0, {8'h0, obs});
    end
  endtask
  // Mid-run reset clears every field and the read-back
  task t_hard_reset;
    begin
      t_write(24'h20071E);
      @(posedge core_clk);
      #1 reset = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 reset = 1'b0;
      repeat (4) @(posedge core_clk);
      #1 chk("hard reset", 24'h0, {7'h0, linkDataOutEn, obs});
      host.xfer({8'h01, 24'h0}, 32, r);
      chk("reset rd", 24'h0, r[23:0]);
    end
  endtask
  task finish_test;
    begin
      if (fails == 0 && checked > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Reset, then scenarios
  initial
  begin
    fails = 0;
    checked = 0;
    reset = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk("reset", 24'h0, {7'h0, linkDataOutEn, obs});
    t_fields();
    t_refused();
    t_soft();
    t_hard_reset();
    finish_test();
  end
  // Watchdog
  initial
  begin
    #400000;
    fails++;
    finish_test();
  end
endmodule // acq_ctl_block_tb
bind acq_ctl_block acq_ctl_block_asserts u_chk (.core_clk, .reset, .linkSelN, .linkDataOutEn, .left_arm_channel_on,
  .gainCode, .clock_source_select, .crystalEnable, .gangOn, .gangMaster, .gangSyncOutEn, .conversion_run,
  .power_on, .softResetPending);
